// ==== wiper_cmd_pkg.sv ====
// Constants for the dual wiper serial command decoder
package wiper_cmd_pkg;
   localparam int WORD_BITS    = 24;
   localparam int CMD_MSB      = 23;
   localparam int CMD_LSB      = 20;
   localparam int ADDR_MSB     = 19;
   localparam int ADDR_LSB     = 16;
   localparam int DATA_MSB     = 15;
   localparam int WIPER_BITS   = 10;
   localparam int NV_BITS      = 16;
   localparam int NV_WORDS     = 16;
   localparam int BIT_CNT_W    = 5;

   localparam logic [3:0] CMD_NOP       = 4'h0;
   localparam logic [3:0] CMD_RESTORE   = 4'h1;
   localparam logic [3:0] CMD_SAVE      = 4'h2;
   localparam logic [3:0] CMD_NV_WRITE  = 4'h3;
   localparam logic [3:0] CMD_SHR_ONE   = 4'h4;
   localparam logic [3:0] CMD_SHR_ALL   = 4'h5;
   localparam logic [3:0] CMD_DEC_ONE   = 4'h6;
   localparam logic [3:0] CMD_DEC_ALL   = 4'h7;
   localparam logic [3:0] CMD_RELOAD    = 4'h8;
   localparam logic [3:0] CMD_NV_READ   = 4'h9;
   localparam logic [3:0] CMD_WIPER_RD  = 4'ha;
   localparam logic [3:0] CMD_WIPER_WR  = 4'hb;
   localparam logic [3:0] CMD_SHL_ONE   = 4'hc;
   localparam logic [3:0] CMD_SHL_ALL   = 4'hd;
   localparam logic [3:0] CMD_INC_ONE   = 4'he;
   localparam logic [3:0] CMD_INC_ALL   = 4'hf;

   localparam logic [9:0]  WIPER_MAX    = 10'h3ff;
   localparam logic [9:0]  WIPER_MID    = 10'h200;
   localparam logic [15:0] NV_RESET     = 16'h0200;
   localparam logic [9:0]  WIPER_RESET  = 10'h000;
endpackage : wiper_cmd_pkg

// ==== dual_wiper_serial_command_decoder.sv ====
// Serial command decoder for two wiper registers and a nonvolatile word array
//
// Notes on behaviour
// RULE1 - Word is 4-bit command, 4-bit address, 16 data bits, MSB first.
// RULE2 - Wiper registers use data bits 9..0; nonvolatile words use all 16.
// RULE3 - Command 0 does nothing at all; here it still clears read_program.
// RULE4 - Command 1 restores one wiper from its word; host follows with a no-op.
// RULE5 - Command 2 saves one wiper into its nonvolatile word.
// RULE6 - Command 3 writes 16 data bits into the addressed nonvolatile word.
// RULE7 - Commands 4 and 5 shift one or both wipers right, stopping at zero.
// RULE8 - Command 6 decrements one wiper, saturating at zero.
// RULE9 - Command 7 decrements both wipers, each saturating at zero.
// RULE10 - Command 8 reloads both wipers from their words, address ignored.
// RULE11 - Command 9 puts addressed nonvolatile word into serial data bytes.
// RULE12 - Command 10 puts addressed wiper value into serial data bytes.
// RULE13 - Command 11 writes received data bits into one wiper.
// RULE14 - Command 12 shifts one wiper left, saturating at all ones.
// RULE15 - Command 13 shifts both wipers left, each saturating at all ones.
// RULE16 - Command 14 increments one wiper, saturating at all ones.
// RULE17 - Command 15 increments both wipers, each saturating at all ones.
// RULE18 - Serial output presents the last 24 bits shifted in, for chaining.
// RULE19 - After a read-back the host sends a full 24-bit word to read it.
// RULE20 - Commands execute only when select returns high.
// RULE21 - Step and shift commands ignore the data bytes.
// RULE22 - At power-on each wiper reloads from its nonvolatile word.
// RULE23 - Input bits sampled on rising serial clock edges, MSB first.
// RULE24 - Write protect blocks changes except commands 1, 8 and preset reloads.
// RULE25 - Ready rises when commands 2, 3, 8, 9, 10 or preset complete.
// RULE26 - Preset pulse reloads wipers at its rising edge; default word is 512.
// RULE27 - Address bit zero picks the channel for single-wiper commands.
`timescale 1ns/10ps
module dual_wiper_serial_command_decoder
   import wiper_cmd_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          sclk,
   input  wire logic                          cs_n,
   input  wire logic                          sdi,
   output logic                               sdo,
   input  wire logic                          wp_n,
   input  wire logic                          preset_n,
   output logic                               ready,
   output logic                               read_program,
   output logic [wiper_cmd_pkg::WIPER_BITS-1:0] wiper0,
   output logic [wiper_cmd_pkg::WIPER_BITS-1:0] wiper1
);
   import wiper_cmd_pkg::*;

   // Link domain: shift register on sclk, which idles while select is high
   logic [WORD_BITS-1:0] shift_reg;
   logic [WORD_BITS-1:0] shift_next;
   logic                 sdo_reg;
   logic                 load_seen_reg;

   // Readback word: written in clk domain while select is high, read in
   // sclk domain only once select is low, so it is stable when sampled.
   logic [NV_BITS-1:0]   rb_data_reg;
   logic                 rb_tgl_reg;

   assign shift_next = {shift_reg[WORD_BITS-2:0], sdi};

   // First edge of a frame after a read-back replaces data bytes. [RULE11] [RULE12]
   // Toggle and word settle a few clk cycles after select rises, long before the
   // next frame; a synchroniser would need sclk edges that only come mid-frame.
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         shift_reg     <= '0;
         load_seen_reg <= 1'b0;
      end else if (rb_tgl_reg != load_seen_reg) begin
         shift_reg     <= {shift_reg[WORD_BITS-2:NV_BITS], rb_data_reg, sdi}; // [RULE23]
         load_seen_reg <= rb_tgl_reg;
      end else begin
         shift_reg     <= shift_next; // [RULE23] [RULE1]
      end
   end

   shift_load_a: assert property (@(posedge sclk) disable iff (rst) // [RULE11]
      rb_tgl_reg != load_seen_reg |=> shift_reg[NV_BITS:1] == $past(rb_data_reg))
      else $error("read-back bytes not loaded");

   // Output changes on falling edge so the host samples it on the rising one
   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= shift_reg[WORD_BITS-1]; // [RULE18]
      end
   end

   // Core domain: synchronise pins
   logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
   logic wp_s1_reg, wp_s2_reg;
   logic pr_s1_reg, pr_s2_reg, pr_s3_reg;
   logic sdo_s1_reg, sdo_s2_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_s1_reg  <= 1'b1;
         cs_s2_reg  <= 1'b1;
         cs_s3_reg  <= 1'b1;
         wp_s1_reg  <= 1'b1;
         wp_s2_reg  <= 1'b1;
         pr_s1_reg  <= 1'b1;
         pr_s2_reg  <= 1'b1;
         pr_s3_reg  <= 1'b1;
         sdo_s1_reg <= 1'b0;
         sdo_s2_reg <= 1'b0;
      end else begin
         cs_s1_reg  <= cs_n;
         cs_s2_reg  <= cs_s1_reg;
         cs_s3_reg  <= cs_s2_reg;
         wp_s1_reg  <= wp_n;
         wp_s2_reg  <= wp_s1_reg;
         pr_s1_reg  <= preset_n;
         pr_s2_reg  <= pr_s1_reg;
         pr_s3_reg  <= pr_s2_reg;
         sdo_s1_reg <= sdo_reg;
         sdo_s2_reg <= sdo_s1_reg;
      end
   end

   // Serial output is retimed into clk so the top output is a clk flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdo <= 1'b0;
      end else begin
         sdo <= sdo_s2_reg; // [RULE18]
      end
   end

   logic cs_rise;
   logic pr_rise;
   logic pr_low;
   assign cs_rise = cs_s2_reg & ~cs_s3_reg;
   assign pr_rise = pr_s2_reg & ~pr_s3_reg;
   assign pr_low  = ~pr_s2_reg;

   // Captured word is stable: sclk is idle while select is high.
   logic [WORD_BITS-1:0] word_cap_reg;
   logic                 exec_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         word_cap_reg <= '0;
         exec_reg     <= 1'b0;
      end else begin
         exec_reg <= cs_rise; // [RULE20]
         if (cs_rise) begin
            word_cap_reg <= shift_reg;
         end
      end
   end

   logic [3:0]            cmd;
   logic [3:0]            addr;
   logic [NV_BITS-1:0]    data;
   logic                  chan;
   assign cmd  = word_cap_reg[CMD_MSB:CMD_LSB];
   assign addr = word_cap_reg[ADDR_MSB:ADDR_LSB];
   assign data = word_cap_reg[DATA_MSB:0];
   assign chan = addr[0]; // [RULE27]

   // Nonvolatile array, no write latency modelled
   logic [NV_BITS-1:0] nv_mem [NV_WORDS];
   logic               wp_active;
   assign wp_active = ~wp_s2_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NV_WORDS; i++) begin
            nv_mem[i] <= NV_RESET; // [RULE26]
         end
      end else if (exec_reg && !wp_active) begin // [RULE24]
         if (cmd == CMD_SAVE) begin
            nv_mem[chan] <= {6'h00, chan ? wiper1 : wiper0}; // [RULE5]
         end else if (cmd == CMD_NV_WRITE) begin
            nv_mem[addr] <= data; // [RULE6] [RULE2]
         end
      end
   end

   // Stores move only on their own command, never under write protect
   save_word_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
      exec_reg && cmd == CMD_SAVE && !wp_active && !chan
      |=> nv_mem[0] == {6'h00, $past(wiper0)}) else $error("wiper save lost");
   nv_write_a: assert property (@(posedge clk) disable iff (rst) // [RULE6]
      exec_reg && cmd == CMD_NV_WRITE && !wp_active
      |=> nv_mem[$past(addr)] == $past(data)) else $error("word write lost");
   nv_protect_a: assert property (@(posedge clk) disable iff (rst) // [RULE24]
      exec_reg && cmd == CMD_NV_WRITE && wp_active
      |=> nv_mem[$past(addr)] == $past(nv_mem[addr])) else $error("protected word changed");

   // Wiper update for one channel; data bytes are never read for steps.
   function automatic logic [9:0] step_val(input logic [3:0] c, input logic [9:0] v);
      logic [9:0] r;
      r = v;
      case (c)
         CMD_SHR_ONE, CMD_SHR_ALL: r = v >> 1; // [RULE7] [RULE21]
         CMD_DEC_ONE, CMD_DEC_ALL: r = (v == '0) ? v : v - 10'h001; // [RULE8] [RULE9]
         CMD_SHL_ONE, CMD_SHL_ALL: r = (v == '0) ? 10'h001 : (v >= WIPER_MID) ? WIPER_MAX : {v[8:0], 1'b0}; // [RULE14] [RULE15]
         CMD_INC_ONE, CMD_INC_ALL: r = (v == WIPER_MAX) ? v : v + 10'h001; // [RULE16] [RULE17]
         default: r = v;
      endcase
      return r;
   endfunction : step_val

   logic boot_reg;
   logic single_cmd;
   logic all_cmd;
   assign single_cmd = (cmd == CMD_SHR_ONE) || (cmd == CMD_DEC_ONE) ||
                       (cmd == CMD_SHL_ONE) || (cmd == CMD_INC_ONE);
   assign all_cmd    = (cmd == CMD_SHR_ALL) || (cmd == CMD_DEC_ALL) ||
                       (cmd == CMD_SHL_ALL) || (cmd == CMD_INC_ALL);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boot_reg <= 1'b1;
      end else begin
         boot_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wiper0 <= WIPER_RESET;
         wiper1 <= WIPER_RESET;
      end else if (boot_reg || pr_rise) begin
         wiper0 <= nv_mem[0][WIPER_BITS-1:0]; // [RULE22] [RULE26]
         wiper1 <= nv_mem[1][WIPER_BITS-1:0];
      end else if (pr_low) begin
         wiper0 <= WIPER_MID; // [RULE26]
         wiper1 <= WIPER_MID;
      end else if (exec_reg) begin
         if (cmd == CMD_RELOAD) begin
            wiper0 <= nv_mem[0][WIPER_BITS-1:0]; // [RULE10] [RULE24]
            wiper1 <= nv_mem[1][WIPER_BITS-1:0];
         end else if (cmd == CMD_RESTORE) begin
            if (chan) wiper1 <= nv_mem[1][WIPER_BITS-1:0]; // [RULE4] [RULE24]
            else      wiper0 <= nv_mem[0][WIPER_BITS-1:0];
         end else if (!wp_active) begin // [RULE24] [RULE3]
            if (cmd == CMD_WIPER_WR) begin
               if (chan) wiper1 <= data[WIPER_BITS-1:0]; // [RULE13] [RULE2]
               else      wiper0 <= data[WIPER_BITS-1:0];
            end else if (all_cmd) begin
               wiper0 <= step_val(cmd, wiper0);
               wiper1 <= step_val(cmd, wiper1);
            end else if (single_cmd) begin
               if (chan) wiper1 <= step_val(cmd, wiper1);
               else      wiper0 <= step_val(cmd, wiper0);
            end
         end
      end
   end

   // Read-program state: set by restore, cleared by a no-op
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         read_program <= 1'b0;
      end else if (exec_reg && cmd == CMD_RESTORE) begin
         read_program <= 1'b1; // [RULE4]
      end else if (exec_reg && cmd == CMD_NOP) begin
         read_program <= 1'b0; // [RULE4]
      end
   end

   rp_set_a: assert property (@(posedge clk) disable iff (rst) // [RULE4]
      exec_reg && cmd == CMD_RESTORE |=> read_program)
      else $error("restore left no read-program state");
   rp_clear_a: assert property (@(posedge clk) disable iff (rst) // [RULE4]
      exec_reg && cmd == CMD_NOP |=> !read_program)
      else $error("no-op kept read-program state");

   // Read-back load, handed to the link side by toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rb_data_reg <= '0;
         rb_tgl_reg  <= 1'b0;
      end else if (exec_reg && cmd == CMD_NV_READ) begin
         rb_data_reg <= nv_mem[addr]; // [RULE11]
         rb_tgl_reg  <= ~rb_tgl_reg;
      end else if (exec_reg && cmd == CMD_WIPER_RD) begin
         rb_data_reg <= {6'h00, chan ? wiper1 : wiper0}; // [RULE12]
         rb_tgl_reg  <= ~rb_tgl_reg;
      end
   end

   rb_nv_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
      exec_reg && cmd == CMD_NV_READ |=> rb_data_reg == $past(nv_mem[addr]))
      else $error("word read-back wrong");
   rb_wiper_a: assert property (@(posedge clk) disable iff (rst) // [RULE12]
      exec_reg && cmd == CMD_WIPER_RD && chan |=> rb_data_reg == {6'h00, $past(wiper1)})
      else $error("wiper read-back wrong");

   // Ready drops at the start of every command, rises when a tracked one is done
   logic ready_cmd;
   assign ready_cmd = (cmd == CMD_SAVE) || (cmd == CMD_NV_WRITE) || (cmd == CMD_RELOAD) ||
                      (cmd == CMD_NV_READ) || (cmd == CMD_WIPER_RD);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready <= 1'b1;
      end else if (pr_low || cs_rise) begin
         ready <= 1'b0;
      end else if (pr_rise || (exec_reg && ready_cmd)) begin
         ready <= 1'b1; // [RULE25]
      end
   end

   // Saturation, protection and no-op quietness of the wipers
   step_dec_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
      exec_reg && cmd == CMD_DEC_ALL && wp_s2_reg && pr_s2_reg && pr_s3_reg && wiper0 == '0
      |=> wiper0 == '0) else $error("wiper0 wrapped below zero");
   inc_sat_a: assert property (@(posedge clk) disable iff (rst) // [RULE17]
      exec_reg && cmd == CMD_INC_ALL && wp_s2_reg && pr_s2_reg && pr_s3_reg && wiper1 == WIPER_MAX
      |=> wiper1 == WIPER_MAX) else $error("wiper1 wrapped above max");
   nop_quiet_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      exec_reg && cmd == CMD_NOP && pr_s2_reg && pr_s3_reg |=> $stable(wiper0) && $stable(wiper1))
      else $error("no-op changed a wiper");
   cs_exec_a: assert property (@(posedge clk) disable iff (rst)
      exec_reg |-> $past(cs_rise)) else $error("command ran without select rising"); // [RULE20]
   wp_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE24]
      exec_reg && !wp_s2_reg && cmd == CMD_WIPER_WR && pr_s2_reg && pr_s3_reg
      |=> $stable(wiper0) && $stable(wiper1)) else $error("write protect ignored");
   ready_done_a: assert property (@(posedge clk) disable iff (rst)
      exec_reg && ready_cmd && pr_s2_reg && !cs_rise |=> ready) else $error("ready missing"); // [RULE25]
   preset_mid_a: assert property (@(posedge clk) disable iff (rst)
      pr_low && !boot_reg && !pr_rise |=> wiper0 == WIPER_MID) else $error("preset low not midscale"); // [RULE26]
   write_wiper_a: assert property (@(posedge clk) disable iff (rst) // [RULE13]
      exec_reg && cmd == CMD_WIPER_WR && wp_s2_reg && pr_s2_reg && pr_s3_reg && !chan
      |=> wiper0 == $past(data[WIPER_BITS-1:0])) else $error("wiper write lost");

   // Ready must fall as soon as a new command is seen
   ready_drop_a: assert property (@(posedge clk) disable iff (rst) // [RULE25]
      cs_rise |=> !ready)
      else $error("ready stayed high over a command");

   // Exact step results; preset activity is excluded since it wins
   dec_one_a: assert property (@(posedge clk) disable iff (rst) // [RULE8]
      exec_reg && cmd == CMD_DEC_ONE && !wp_active && !chan && !pr_low && !pr_rise && wiper0 != '0
      |=> wiper0 == $past(wiper0) - 10'h001) else $error("wiper0 decrement wrong");
   inc_one_a: assert property (@(posedge clk) disable iff (rst) // [RULE16]
      exec_reg && cmd == CMD_INC_ONE && !wp_active && chan && !pr_low && !pr_rise && wiper1 != WIPER_MAX
      |=> wiper1 == $past(wiper1) + 10'h001) else $error("wiper1 increment wrong");
   shr_one_a: assert property (@(posedge clk) disable iff (rst) // [RULE7]
      exec_reg && cmd == CMD_SHR_ONE && !wp_active && !chan && !pr_low && !pr_rise
      |=> wiper0 == {1'b0, $past(wiper0[WIPER_BITS-1:1])}) else $error("wiper0 right shift wrong");
   shl_top_a: assert property (@(posedge clk) disable iff (rst) // [RULE14]
      exec_reg && cmd == CMD_SHL_ONE && !wp_active && chan && !pr_low && !pr_rise && wiper1 >= WIPER_MID
      |=> wiper1 == WIPER_MAX) else $error("wiper1 left shift not full scale");
   chan_other_a: assert property (@(posedge clk) disable iff (rst) // [RULE27]
      exec_reg && single_cmd && chan && !pr_low && !pr_rise
      |=> $stable(wiper0)) else $error("wrong channel stepped");
   restore_one_a: assert property (@(posedge clk) disable iff (rst) // [RULE4]
      exec_reg && cmd == CMD_RESTORE && !chan && !pr_low && !pr_rise
      |=> wiper0 == $past(nv_mem[0][WIPER_BITS-1:0])) else $error("restore wrong");
   reload_both_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
      exec_reg && cmd == CMD_RELOAD && !pr_low && !pr_rise
      |=> wiper0 == $past(nv_mem[0][WIPER_BITS-1:0]) && wiper1 == $past(nv_mem[1][WIPER_BITS-1:0]))
      else $error("reload wrong");
   boot_load_a: assert property (@(posedge clk) disable iff (rst) // [RULE22]
      boot_reg |=> wiper1 == $past(nv_mem[1][WIPER_BITS-1:0]))
      else $error("power-on refresh missing");
   wiper_idle_a: assert property (@(posedge clk) disable iff (rst) // [RULE20]
      !exec_reg && !boot_reg && !pr_rise && !pr_low
      |=> $stable(wiper0) && $stable(wiper1)) else $error("wiper moved without a command");
   inc_all_a: assert property (@(posedge clk) disable iff (rst) // [RULE17]
      exec_reg && cmd == CMD_INC_ALL && !wp_active && !pr_low && !pr_rise && wiper0 != WIPER_MAX
      |=> wiper0 == $past(wiper0) + 10'h001) else $error("wiper0 gang increment wrong");
   dec_all_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
      exec_reg && cmd == CMD_DEC_ALL && !wp_active && !pr_low && !pr_rise && wiper1 != '0
      |=> wiper1 == $past(wiper1) - 10'h001) else $error("wiper1 gang decrement wrong");
   shr_all_a: assert property (@(posedge clk) disable iff (rst) // [RULE7]
      exec_reg && cmd == CMD_SHR_ALL && !wp_active && !pr_low && !pr_rise
      |=> wiper1 == {1'b0, $past(wiper1[WIPER_BITS-1:1])}) else $error("wiper1 gang right shift wrong");
   shl_all_a: assert property (@(posedge clk) disable iff (rst) // [RULE15]
      exec_reg && cmd == CMD_SHL_ALL && !wp_active && !pr_low && !pr_rise && wiper0 >= WIPER_MID
      |=> wiper0 == WIPER_MAX) else $error("wiper0 gang left shift not full scale");
   write_second_a: assert property (@(posedge clk) disable iff (rst) // [RULE13]
      exec_reg && cmd == CMD_WIPER_WR && !wp_active && chan && !pr_low && !pr_rise
      |=> wiper1 == $past(data[WIPER_BITS-1:0])) else $error("wiper1 write lost");
endmodule : dual_wiper_serial_command_decoder

// ==== serial_host_model.sv ====
// Host model that frames 24-bit serial command words for the decoder
`timescale 1ns/10ps
module serial_host_model (
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   // Link clock 48 ns, runs only inside a frame
   task automatic xfer(input logic [23:0] word, output logic [23:0] got);
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi = word[i];
         #24;
         got[i] = sdo;
         sclk = 1'b1;
         #24;
         sclk = 1'b0;
      end
      #24;
      cs_n = 1'b1;
      // Released line flips so a stale bit cannot pass
      sdi = ~sdi;
      // Spacing well above the eight-cycle minimum plus execution
      #200;
   endtask : xfer
endmodule : serial_host_model

// ==== dual_wiper_serial_command_decoder_test.sv ====
// Self-checking bench for the dual wiper serial command decoder
`timescale 1ns/10ps
module dual_wiper_serial_command_decoder_test;
   import wiper_cmd_pkg::*;
   logic                  clk;
   logic                  rst;
   logic                  sclk;
   logic                  cs_n;
   logic                  sdi;
   logic                  sdo;
   logic                  wp_n;
   logic                  preset_n;
   logic                  ready;
   logic                  read_program;
   logic [WIPER_BITS-1:0] wiper0;
   logic [WIPER_BITS-1:0] wiper1;
   logic [23:0]           got;
   int                    miscompares = 0;
   int                    checks = 0;
   int                    cycles = 0;

   dual_wiper_serial_command_decoder u_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
      .sdo(sdo), .wp_n(wp_n), .preset_n(preset_n), .ready(ready), .read_program(read_program),
      .wiper0(wiper0), .wiper1(wiper1));
   serial_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude

   // Ceiling is about four times the expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         $display("[FAIL] run length expected below 40000 cycles seen 40000");
         conclude();
      end
   end

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] seen);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
      u_host.xfer({c, a, d}, got);
   endtask : cmd

   task automatic step(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d,
                       input logic [9:0] e0, input logic [9:0] e1);
      cmd(c, a, d);
      chk("wiper0", {14'h0, e0}, {14'h0, wiper0});
      chk("wiper1", {14'h0, e1}, {14'h0, wiper1});
   endtask : step

   task automatic t_reset;
      chk("wiper0", {14'h0, NV_RESET[9:0]}, {14'h0, wiper0});
      chk("wiper1", {14'h0, NV_RESET[9:0]}, {14'h0, wiper1});
      chk("read_program", 24'h0, {23'h0, read_program});
      $display("t_reset done");
   endtask : t_reset

   task automatic t_write;
      step(CMD_WIPER_WR, 4'h0, 16'hfd55, 10'h155, WIPER_MID);
      step(CMD_WIPER_WR, 4'h3, 16'h02aa, 10'h155, 10'h2aa);
      chk("ready", 24'h0, {23'h0, ready});
      step(CMD_NOP, 4'h1, 16'hffff, 10'h155, 10'h2aa);
      chk("chain", {CMD_WIPER_WR, 4'h3, 16'h02aa}, got);
      cmd(CMD_WIPER_RD, 4'h1, 16'h1234);
      chk("ready", 24'h1, {23'h0, ready});
      cmd(CMD_NOP, 4'h0, 16'h0000);
      chk("wiper read", {CMD_WIPER_RD, 4'h1, 16'h02aa}, got);
      $display("t_write done");
   endtask : t_write

   task automatic t_step;
      step(CMD_WIPER_WR, 4'h0, 16'h03fe, 10'h3fe, 10'h2aa);
      step(CMD_INC_ONE, 4'h0, 16'hffff, 10'h3ff, 10'h2aa);
      step(CMD_INC_ONE, 4'h0, 16'h0000, 10'h3ff, 10'h2aa);
      step(CMD_WIPER_WR, 4'h1, 16'h0001, 10'h3ff, 10'h001);
      step(CMD_DEC_ALL, 4'h0, 16'h0000, 10'h3fe, 10'h000);
      step(CMD_DEC_ONE, 4'h1, 16'h5555, 10'h3fe, 10'h000);
      step(CMD_INC_ALL, 4'h0, 16'h0000, 10'h3ff, 10'h001);
      step(CMD_DEC_ONE, 4'h0, 16'h0000, 10'h3fe, 10'h001);
      step(CMD_SHL_ONE, 4'h1, 16'h0000, 10'h3fe, 10'h002);
      step(CMD_SHL_ALL, 4'h0, 16'h0000, 10'h3ff, 10'h004);
      step(CMD_SHR_ONE, 4'h0, 16'hffff, 10'h1ff, 10'h004);
      step(CMD_SHR_ALL, 4'h0, 16'h0000, 10'h0ff, 10'h002);
      step(CMD_WIPER_WR, 4'h0, 16'h0000, 10'h000, 10'h002);
      step(CMD_SHL_ONE, 4'h0, 16'h0000, 10'h001, 10'h002);
      step(CMD_SHR_ALL, 4'h0, 16'h0000, 10'h000, 10'h001);
      step(CMD_SHR_ALL, 4'h0, 16'h0000, 10'h000, 10'h000);
      $display("t_step done");
   endtask : t_step

   task automatic t_nv;
      cmd(CMD_NV_WRITE, 4'h5, 16'habcd);
      chk("ready", 24'h1, {23'h0, ready});
      cmd(CMD_NV_READ, 4'h5, 16'h0000);
      cmd(CMD_NOP, 4'h0, 16'h0000);
      chk("nv read", {CMD_NV_READ, 4'h5, 16'habcd}, got);
      step(CMD_WIPER_WR, 4'h0, 16'h0123, 10'h123, 10'h000);
      cmd(CMD_SAVE, 4'h0, 16'h0000);
      step(CMD_WIPER_WR, 4'h0, 16'h0000, 10'h000, 10'h000);
      step(CMD_RESTORE, 4'h0, 16'h0000, 10'h123, 10'h000);
      chk("read_program", 24'h1, {23'h0, read_program});
      cmd(CMD_NOP, 4'h0, 16'h0000);
      chk("read_program", 24'h0, {23'h0, read_program});
      cmd(CMD_NV_WRITE, 4'h1, 16'hfc77);
      step(CMD_RELOAD, 4'h7, 16'h0000, 10'h123, 10'h077);
      $display("t_nv done");
   endtask : t_nv

   task automatic t_protect;
      step(CMD_WIPER_WR, 4'h0, 16'h0055, 10'h055, 10'h077);
      @(posedge clk);
      wp_n <= 1'b0;
      step(CMD_WIPER_WR, 4'h0, 16'h0300, 10'h055, 10'h077);
      step(CMD_INC_ALL, 4'h0, 16'h0000, 10'h055, 10'h077);
      cmd(CMD_NV_WRITE, 4'h0, 16'h0000);
      step(CMD_RELOAD, 4'h0, 16'h0000, 10'h123, 10'h077);
      cmd(CMD_NOP, 4'h0, 16'h0000);
      @(posedge clk);
      wp_n <= 1'b1;
      $display("t_protect done");
   endtask : t_protect

   task automatic t_preset;
      step(CMD_WIPER_WR, 4'h1, 16'h0100, 10'h123, 10'h100);
      @(posedge clk);
      preset_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk("wiper0", {14'h0, WIPER_MID}, {14'h0, wiper0});
      chk("wiper1", {14'h0, WIPER_MID}, {14'h0, wiper1});
      preset_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk("wiper0", 24'h123, {14'h0, wiper0});
      chk("wiper1", 24'h077, {14'h0, wiper1});
      chk("ready", 24'h1, {23'h0, ready});
      $display("t_preset done");
   endtask : t_preset

   initial begin
      rst      = 1'b1;
      wp_n     = 1'b1;
      preset_n = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      t_reset();
      t_write();
      t_step();
      t_nv();
      t_protect();
      t_preset();
      conclude();
   end
endmodule : dual_wiper_serial_command_decoder_test
